// ---- sspc_counter.sv ----
`default_nettype none
// ------------------------------------------------
// Scan-synchronised high-speed pulse counter
// ------------------------------------------------
module sspc_counter
	import sspc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// External pins
	input wire logic pulse_a_input,
	input wire logic dir_or_b_phase_input,
	input wire logic hw_count_reset_input,
	// Program engine
	input wire logic scan_end_strobe,
	input wire logic plc_run,
	input wire logic program_load,
	input wire sspc_cfg_s cfg,
	input wire sspc_words_s words,
	input wire sspc_flags_s flags,
	// Program view
	output logic [SSPC_WORD_W-1:0] count_value_hi,
	output logic [SSPC_WORD_W-1:0] count_value_lo,
	output logic [SSPC_WORD_W-1:0] active_preset_hi,
	output logic [SSPC_WORD_W-1:0] active_preset_lo,
	output sspc_status_s status,
	output logic count_dir_up,
	output logic counting,
	// Comparison outputs
	output logic compare_out_first,
	output logic compare_out_second
);
	// ------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------
	logic [2:0] pins_sync;

	sspc_sync #(.WIDTH(3)) u_sync
	(
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.pin_in({hw_count_reset_input, dir_or_b_phase_input, pulse_a_input}),
		.pin_sync(pins_sync)
	);

	// ------------------------------------------------
	// State
	// ------------------------------------------------
	typedef struct packed
	{
		sspc_state_e run_st;
		logic run_prev;
		logic gate_q;
		logic gate_prev;
		logic a_q;
		logic b_q;
		logic hwr_q;
		logic [SSPC_CNT_W-1:0] count;
		logic [SSPC_CNT_W-1:0] shown;
		logic [SSPC_CNT_W-1:0] preset;
		logic second_stage;
		logic held;
		logic out1;
		logic out2;
		logic dir_up;
		sspc_status_s ev;
		sspc_status_s stat;
	} sspc_state_s;

	sspc_state_s s_q;
	sspc_state_s s_d;

	logic a_s;
	logic b_s;
	logic hwr_s;
	logic a_rise;
	logic a_fall;
	logic b_rise;
	logic b_fall;
	logic step_en;
	logic step_up;
	logic [SSPC_CNT_W-1:0] preset1_w;
	logic [SSPC_CNT_W-1:0] preset2_w;
	logic [SSPC_CNT_W-1:0] reload_w;
	// Compare outputs set in this cycle; a set beats a clear in the same cycle
	logic set1_w;
	logic set2_w;

	assign a_s = pins_sync[0];
	assign b_s = pins_sync[1];
	assign hwr_s = pins_sync[2];
	assign a_rise = a_s & ~s_q.a_q;
	assign a_fall = ~a_s & s_q.a_q;
	assign b_rise = b_s & ~s_q.b_q;
	assign b_fall = ~b_s & s_q.b_q;
	// Word pairs joined upper:lower
	assign preset1_w = {words.preset_value_hi, words.preset_value_lo};
	assign preset2_w = {words.preset2_value_hi, words.preset2_value_lo};
	assign reload_w = {words.reload_value_hi, words.reload_value_lo};

	// Step decode per mode; quadrature direction from phase relation
	always_comb
	begin
		step_en = 1'b0;
		step_up = 1'b1;
		case (cfg.mode)
			SSPC_MODE_ADD:
			begin
				step_en = a_rise;
			end
			SSPC_MODE_UPDN:
			begin
				step_en = a_rise;
				step_up = b_s;
			end
			SSPC_MODE_QUAD2:
			begin
				// Both A edges; A leading B means B low at A rise
				step_en = a_rise | a_fall;
				step_up = a_rise ? ~b_s : b_s;
			end
			SSPC_MODE_QUAD4:
			begin
				step_en = a_rise | a_fall | b_rise | b_fall;
				if (a_rise | a_fall)
					step_up = a_s ^ b_s;
				else
					step_up = ~(a_s ^ b_s);
			end
			default:
			begin
				step_en = 1'b0;
			end
		endcase
	end

	// Next state
	always_comb
	begin
		s_d = s_q;
		s_d.a_q = a_s;
		s_d.b_q = b_s;
		s_d.hwr_q = hwr_s;
		set1_w = 1'b0;
		set2_w = 1'b0;
		// Stage one compares against the live preset 1 words
		if (!s_q.second_stage)
			s_d.preset = preset1_w;

		// Counting between scan ends uses the gate latched at the last one
		if (s_q.run_st == SSPC_ST_COUNT && s_q.gate_q && !s_q.held && step_en)
		begin
			if (step_up)
			begin
				if (s_q.count == SSPC_CNT_MAX)
				begin
					s_d.count = SSPC_CNT_ZERO;
					s_d.ev.overflow_pulse = cfg.ovf_enable;
					s_d.dir_up = 1'b1;
				end
				else
					s_d.count = s_q.count + SSPC_CNT_ONE;
			end
			else
			begin
				if (s_q.count == SSPC_CNT_ZERO)
				begin
					s_d.count = SSPC_CNT_MAX;
					s_d.ev.underflow_pulse = cfg.unf_enable;
					s_d.dir_up = 1'b0;
				end
				else
					s_d.count = s_q.count - SSPC_CNT_ONE;
			end
			// Compare on the new count
			if (s_d.count == s_q.preset)
			begin
				s_d.ev.compare_match_pulse = 1'b1;
				s_d.dir_up = step_up;
				if (cfg.two_presets && s_q.second_stage)
				begin
					s_d.out2 = 1'b1;
					set2_w = 1'b1;
					if (cfg.clear_on_second)
						s_d.count = SSPC_CNT_ZERO;
					s_d.second_stage = 1'b0;
					s_d.preset = preset1_w;
				end
				else
				begin
					s_d.out1 = 1'b1;
					set1_w = 1'b1;
					if (cfg.two_presets)
					begin
						s_d.preset = preset2_w;
						s_d.second_stage = 1'b1;
					end
					else if (cfg.keep_on_match)
						s_d.held = 1'b1;
				end
			end
		end

		// Hardware reset pin edge acts at once
		if (cfg.hw_reset_enable && hwr_s && !s_q.hwr_q)
		begin
			s_d.count = reload_w;
			s_d.held = 1'b0;
			s_d.ev.reset_done_pulse = 1'b1;
		end

		// Program load stops counting until run is re-entered
		if (program_load)
			s_d.run_st = SSPC_ST_STOP;

		// End-of-scan processing
		if (scan_end_strobe)
		begin
			s_d.gate_q = flags.count_gate_flag;
			s_d.gate_prev = s_q.gate_q;
			s_d.run_prev = plc_run;
			s_d.shown = s_d.count;
			s_d.stat = s_d.ev;
			s_d.ev = '0;
			if (flags.sw_count_reset_flag)
			begin
				s_d.count = reload_w;
				s_d.shown = reload_w;
				s_d.held = 1'b0;
				s_d.stat.reset_done_pulse = 1'b1;
			end
			// A match in the strobe cycle keeps its output on; none is lost
			if (flags.compare_out_clear_flag)
			begin
				if (!set1_w)
					s_d.out1 = 1'b0;
				if (!set2_w)
					s_d.out2 = 1'b0;
			end
			case (s_q.run_st)
				SSPC_ST_STOP:
				begin
					// Gate already on at stop-to-run starts directly
					// Needs run off at one scan end and on at the next, so a load stays halted
					if (plc_run && !s_q.run_prev && !program_load)
						s_d.run_st = flags.count_gate_flag ? SSPC_ST_COUNT : SSPC_ST_ARMED;
				end
				SSPC_ST_ARMED:
				begin
					if (!plc_run)
						s_d.run_st = SSPC_ST_STOP;
					else if (flags.count_gate_flag && !s_q.gate_q)
						s_d.run_st = SSPC_ST_COUNT;
				end
				SSPC_ST_COUNT:
				begin
					if (!plc_run)
						s_d.run_st = SSPC_ST_STOP;
				end
				default:
				begin
					s_d.run_st = SSPC_ST_STOP;
				end
			endcase
			if (program_load)
				s_d.run_st = SSPC_ST_STOP;
		end
	end

	// State register
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			s_q <= '0;
			s_q.run_st <= SSPC_ST_STOP;
			s_q.dir_up <= 1'b1; // Default is adding direction
		end
		else
			s_q <= s_d;
	end

	// Active preset is preset 1 in stage one, preset 2 after the first match when two presets are set
	// Preset 1 word edits reach the compare one cycle later; preset 2 words are taken once, at the first match
	// ------------------------------------------------
	// Outputs
	// ------------------------------------------------
	assign count_value_hi = s_q.shown[SSPC_CNT_W-1:SSPC_WORD_W];
	assign count_value_lo = s_q.shown[SSPC_WORD_W-1:0];
	assign active_preset_hi = s_q.preset[SSPC_CNT_W-1:SSPC_WORD_W];
	assign active_preset_lo = s_q.preset[SSPC_WORD_W-1:0];
	assign status = s_q.stat;
	// Adding mode always reports up; up/down mode shows the select pin
	assign count_dir_up = (cfg.mode == SSPC_MODE_ADD) ? 1'b1
		: ((cfg.mode == SSPC_MODE_UPDN) ? s_q.b_q : s_q.dir_up);
	assign counting = (s_q.run_st == SSPC_ST_COUNT) && s_q.gate_q && !s_q.held;
	assign compare_out_first = s_q.out1;
	assign compare_out_second = s_q.out2;
endmodule
`default_nettype wire

// ---- sspc_pkg.sv ----
`default_nettype none
package sspc_pkg;
	localparam int unsigned SSPC_CNT_W = 32;
	localparam int unsigned SSPC_WORD_W = 16;
	localparam logic [SSPC_CNT_W-1:0] SSPC_CNT_ZERO = 32'h00000000;
	localparam logic [SSPC_CNT_W-1:0] SSPC_CNT_MAX = 32'hFFFFFFFF;
	localparam logic [SSPC_CNT_W-1:0] SSPC_CNT_ONE = 32'h00000001;

	// Counting modes
	typedef enum logic [1:0]
	{
		SSPC_MODE_ADD = 2'h0,
		SSPC_MODE_UPDN = 2'h1,
		SSPC_MODE_QUAD2 = 2'h3,
		SSPC_MODE_QUAD4 = 2'h2
	} sspc_mode_e;

	// Run control states, Gray along stop -> armed -> counting
	typedef enum logic [1:0]
	{
		SSPC_ST_STOP = 2'h0,
		SSPC_ST_ARMED = 2'h1,
		SSPC_ST_COUNT = 2'h3
	} sspc_state_e;

	// Static configuration from the settings dialog
	typedef struct packed
	{
		sspc_mode_e mode;
		logic two_presets;
		logic keep_on_match;
		logic clear_on_second;
		logic ovf_enable;
		logic unf_enable;
		logic hw_reset_enable;
	} sspc_cfg_s;

	// Split 32-bit values as the program writes them
	typedef struct packed
	{
		logic [SSPC_WORD_W-1:0] preset_value_hi;
		logic [SSPC_WORD_W-1:0] preset_value_lo;
		logic [SSPC_WORD_W-1:0] preset2_value_hi;
		logic [SSPC_WORD_W-1:0] preset2_value_lo;
		logic [SSPC_WORD_W-1:0] reload_value_hi;
		logic [SSPC_WORD_W-1:0] reload_value_lo;
	} sspc_words_s;

	// Program-set relay flags, sampled at end of scan
	typedef struct packed
	{
		logic count_gate_flag;
		logic compare_out_clear_flag;
		logic sw_count_reset_flag;
	} sspc_flags_s;

	// One-scan status pulses
	typedef struct packed
	{
		logic reset_done_pulse;
		logic compare_match_pulse;
		logic overflow_pulse;
		logic underflow_pulse;
	} sspc_status_s;

	// Synchroniser depth for pins
	localparam int unsigned SSPC_SYNC_STAGES = 2;
endpackage
`default_nettype wire

// ---- sspc_sync.sv ----
`default_nettype none
// ------------------------------------------------
// Two-flop synchroniser for a group of pin levels
// ------------------------------------------------
module sspc_sync
	import sspc_pkg::*;
#(
	parameter int unsigned WIDTH = 3
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Levels
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync
);
	typedef struct packed
	{
		logic [WIDTH-1:0] meta_q;
		logic [WIDTH-1:0] sync_q;
	} sspc_sync_s;

	sspc_sync_s st_q;
	sspc_sync_s st_d;

	// First stage feeds only the second stage
	always_comb
	begin
		st_d = st_q;
		st_d.meta_q = pin_in;
		st_d.sync_q = st_q.meta_q;
	end

	// State register
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign pin_sync = st_q.sync_q;
endmodule
`default_nettype wire

// ---- sspc_counter_properties.sv ----
`default_nettype none
// --------------------------------
// Port checks of the counter
// --------------------------------
module sspc_counter_properties
	import sspc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Watched ports
	input wire logic scan_end_strobe,
	input wire logic plc_run,
	input wire logic program_load,
	input wire sspc_flags_s flags,
	input wire logic [SSPC_WORD_W-1:0] count_value_hi,
	input wire logic [SSPC_WORD_W-1:0] count_value_lo,
	input wire sspc_status_s status,
	input wire logic counting,
	input wire logic compare_out_first,
	input wire logic compare_out_second
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// Run level at the previous scan end, to spot a stop-to-run change
	logic run_seen_q;
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			run_seen_q <= 1'b0;
		else if (scan_end_strobe)
			run_seen_q <= plc_run;
	end
	// Requests taken at the end of a scan
	sequence s_scan_go;
		scan_end_strobe && plc_run && !run_seen_q && flags.count_gate_flag && !program_load;
	endsequence
	sequence s_scan_halt;
		scan_end_strobe && (!plc_run || !flags.count_gate_flag);
	endsequence
	a_view_per_scan: assert property (!$past(scan_end_strobe) |-> $stable({count_value_hi, count_value_lo}))
		else $error("count view moved inside a scan");
	a_status_per_scan: assert property (!$past(scan_end_strobe) |-> $stable(status))
		else $error("status pulse moved inside a scan");
	a_gate_run_go: assert property (s_scan_go |=> counting)
		else $error("counting did not start");
	a_gate_off_halt: assert property (s_scan_halt |=> !counting)
		else $error("counting did not stop");
	a_load_halts: assert property (program_load |=> !counting)
		else $error("program load left counting on");
	a_gate_at_end: assert property (!$past(scan_end_strobe) && !$past(program_load) |->
		$stable(counting) || ($fell(counting) && $rose(compare_out_first)))
		else $error("counting changed inside a scan");
	a_first_out_hold: assert property (compare_out_first && !(scan_end_strobe && flags.compare_out_clear_flag)
		|=> compare_out_first)
		else $error("first output dropped without clear");
	a_second_out_hold: assert property (compare_out_second && !(scan_end_strobe && flags.compare_out_clear_flag)
		|=> compare_out_second)
		else $error("second output dropped without clear");
endmodule
bind sspc_counter sspc_counter_properties u_props (.sys_clk(sys_clk), .reset_n(reset_n),
	.scan_end_strobe(scan_end_strobe), .plc_run(plc_run), .program_load(program_load), .flags(flags),
	.count_value_hi(count_value_hi), .count_value_lo(count_value_lo), .status(status), .counting(counting),
	.compare_out_first(compare_out_first), .compare_out_second(compare_out_second));
`default_nettype wire

// ---- sspc_encoder_model.sv ----
`default_nettype none
// --------------------------------
// Pulse source and rotary encoder
// --------------------------------
module sspc_encoder_model
(
	// Clock
	input wire logic sys_clk,
	// Pin levels
	output logic pulse_a = 1'b0,
	output logic line_b = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] phase_q = 2'h0;
	// One quadrature step; A changes first when moving up
	task automatic quad_step(input logic up);
		phase_q = up ? phase_q + 2'h1 : phase_q - 2'h1;
		{line_b, pulse_a} = phase_q ^ (phase_q >> 1);
		repeat (4) @(negedge sys_clk);
	endtask
	// Direction set well before the pulse, levels held 3 cycles
	task automatic pulse(input logic up);
		line_b = up;
		repeat (3) @(negedge sys_clk);
		pulse_a = 1'b1;
		repeat (3) @(negedge sys_clk);
		pulse_a = 1'b0;
		repeat (3) @(negedge sys_clk);
	endtask
endmodule
`default_nettype wire

// ---- tb_sspc_counter.sv ----
`default_nettype none
module tb_sspc_counter import sspc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic hw_rst = 1'b0;
	logic strobe = 1'b0;
	logic run = 1'b0;
	logic load = 1'b0;
	logic pa, pb, counting, out1, out2, dir_up;
	sspc_cfg_s cfg = '0;
	sspc_words_s words = '0;
	sspc_flags_s flags = '0;
	sspc_status_s status;
	logic [15:0] cv_hi, cv_lo, ap_hi, ap_lo;
	logic [31:0] seed = 32'h0000C41E;
	logic [31:0] exp_cnt, rnd;
	int failures = 0;
	int n_checks = 0;
	// --------------------------------
	// Clock, model and design
	// --------------------------------
	always #50 sys_clk = ~sys_clk;
	sspc_encoder_model enc (.sys_clk(sys_clk), .pulse_a(pa), .line_b(pb));
	sspc_counter DUT (.sys_clk(sys_clk), .reset_n(reset_n), .pulse_a_input(pa), .dir_or_b_phase_input(pb),
		.hw_count_reset_input(hw_rst), .scan_end_strobe(strobe), .plc_run(run), .program_load(load), .cfg(cfg),
		.words(words), .flags(flags), .count_value_hi(cv_hi), .count_value_lo(cv_lo), .active_preset_hi(ap_hi),
		.active_preset_lo(ap_lo), .status(status), .count_dir_up(dir_up), .counting(counting),
		.compare_out_first(out1),
		.compare_out_second(out2));
	// --------------------------------
	// Helpers
	// --------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Count after one pulse, wrapping both ways
	function automatic logic [31:0] nxt(input logic [31:0] c, input logic up);
		return up ? c + 32'h00000001 : c - 32'h00000001;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Strobe lands late so pin edges have settled; view read after it
	task automatic scan();
		repeat (19) @(negedge sys_clk);
		strobe = 1'b1;
		@(negedge sys_clk);
		strobe = 1'b0;
		@(negedge sys_clk);
	endtask
	task automatic sw_load(input logic [31:0] v);
		{words.reload_value_hi, words.reload_value_lo} = v;
		flags.sw_count_reset_flag = 1'b1;
		scan();
		flags.sw_count_reset_flag = 1'b0;
		exp_cnt = v;
	endtask
	task automatic wrap_up();
		if (failures == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Hang guard, about fourteen times the expected run
	initial
	begin
		#1000000;
		failures++;
		wrap_up();
	end
	// --------------------------------
	// Main sequence
	// --------------------------------
	initial
	begin
		cfg.mode = SSPC_MODE_UPDN;
		cfg.ovf_enable = 1'b1;
		cfg.unf_enable = 1'b1;
		cfg.hw_reset_enable = 1'b1;
		repeat (2) @(negedge sys_clk);
		reset_n = 1'b1;
		sw_load(xs() >> 1);
		chk({cv_hi, cv_lo}, exp_cnt);
		{words.reload_value_hi, words.reload_value_lo} = xs();
		{words.preset_value_hi, words.preset_value_lo} = xs();
		exp_cnt = {words.reload_value_hi, words.reload_value_lo};
		hw_rst = 1'b1;
		repeat (3) @(negedge sys_clk);
		hw_rst = 1'b0;
		scan();
		chk({cv_hi, cv_lo}, exp_cnt);
		chk(status.reset_done_pulse, 1'b1);
		scan();
		chk(status.reset_done_pulse, 1'b0);
		run = 1'b1;
		flags.count_gate_flag = 1'b1;
		scan();
		chk(counting, 1'b1);
		for (int i = 0; i < 12; i++)
		begin
			rnd = xs();
			enc.pulse(rnd[0]);
			exp_cnt = nxt(exp_cnt, rnd[0]);
		end
		scan();
		chk({cv_hi, cv_lo}, exp_cnt);
		chk(dir_up, rnd[0]);
		// Gate off, then program load: pulses dropped
		flags.count_gate_flag = 1'b0;
		scan();
		enc.pulse(1'b1);
		flags.count_gate_flag = 1'b1;
		scan();
		load = 1'b1;
		@(negedge sys_clk);
		load = 1'b0;
		enc.pulse(1'b1);
		scan();
		chk({cv_hi, cv_lo}, exp_cnt);
		chk(counting, 1'b0);
		// Leave run for one scan; gate still on, so the return starts counting
		run = 1'b0;
		scan();
		run = 1'b1;
		scan();
		enc.pulse(1'b1);
		exp_cnt = nxt(exp_cnt, 1'b1);
		scan();
		chk({cv_hi, cv_lo}, exp_cnt);
		// Wrap at both ends
		sw_load(SSPC_CNT_MAX);
		enc.pulse(1'b1);
		scan();
		chk({cv_hi, cv_lo}, SSPC_CNT_ZERO);
		chk(status.overflow_pulse, 1'b1);
		enc.pulse(1'b0);
		scan();
		chk({cv_hi, cv_lo}, SSPC_CNT_MAX);
		chk(status.underflow_pulse, 1'b1);
		// Match with keep: third pulse is held off
		cfg.keep_on_match = 1'b1;
		exp_cnt = SSPC_CNT_MAX - 32'h00000002;
		{words.preset_value_hi, words.preset_value_lo} = exp_cnt;
		repeat (3) enc.pulse(1'b0);
		scan();
		chk({cv_hi, cv_lo}, exp_cnt);
		chk({status.compare_match_pulse, out1}, 2'h3);
		{words.preset_value_hi, words.preset_value_lo} = 32'h00A5005A;
		cfg.keep_on_match = 1'b0;
		scan();
		chk({status.compare_match_pulse, out1}, 2'h1);
		// Clear the output; the software reset also releases the keep hold
		flags.compare_out_clear_flag = 1'b1;
		sw_load(exp_cnt);
		flags.compare_out_clear_flag = 1'b0;
		chk(out1, 1'b0);
		// Quadrature, four edges per cycle
		flags.count_gate_flag = 1'b0;
		scan();
		enc.pulse(1'b0);
		cfg.mode = SSPC_MODE_QUAD4;
		cfg.ovf_enable = 1'b0;
		cfg.unf_enable = 1'b0;
		cfg.hw_reset_enable = 1'b0;
		flags.count_gate_flag = 1'b1;
		scan();
		repeat (4) enc.quad_step(1'b1);
		repeat (2) enc.quad_step(1'b0);
		// Reset pin and wrap pulses stay silent while their options are off
		hw_rst = 1'b1;
		repeat (3) @(negedge sys_clk);
		hw_rst = 1'b0;
		scan();
		chk({cv_hi, cv_lo}, exp_cnt + 32'h00000002);
		chk({status.reset_done_pulse, status.overflow_pulse, status.underflow_pulse}, 3'h0);
		// Two presets: first match swaps in preset 2, second match clears
		cfg.two_presets = 1'b1;
		cfg.clear_on_second = 1'b1;
		{words.preset_value_hi, words.preset_value_lo} = 32'h00000002;
		sw_load(SSPC_CNT_ZERO);
		rnd = xs();
		exp_cnt = 32'h00000003 + {30'h0, rnd[1:0]};
		{words.preset2_value_hi, words.preset2_value_lo} = exp_cnt;
		repeat (2) enc.quad_step(1'b1);
		scan();
		chk({ap_hi, ap_lo}, exp_cnt);
		chk({cv_hi, cv_lo}, 32'h00000002);
		chk({status.compare_match_pulse, out1, out2}, 3'h6);
		repeat (rnd[1:0] + 1) enc.quad_step(1'b1);
		scan();
		chk({cv_hi, cv_lo}, SSPC_CNT_ZERO);
		chk({status.compare_match_pulse, out1, out2}, 3'h7);
		chk({ap_hi, ap_lo}, 32'h00000002);
		wrap_up();
	end
endmodule
`default_nettype wire
